// >>> pkg/nvs_consts.svh
`ifndef NVS_CONSTS_SVH
`define NVS_CONSTS_SVH

// ==========================================================
// clock and pin timing
`define NVS_CLK_MHZ 250
`define NVS_RD_CYCLE_NS 25
`define NVS_WR_PULSE_NS 20
`define NVS_HW_PULSE_MIN_NS 15
`define NVS_NO_WRITE_RELEASE_NS 25
`define NVS_SOFT_SEQ_LATENCY_US 100
`define NVS_SYNC_STAGES 2
`define NVS_GAP_CYC 1

// ==========================================================
// soft command sequence
`define NVS_SEQ_LEN 6
`define NVS_SEQ_LAST 5

// ==========================================================
// widths
`define NVS_ADDR_W 15
`define NVS_DATA_W 8
`define NVS_TMR_W 16

`endif

// >>> pkg/nvs_pkg.sv
package nvs_pkg;

  // ==========================================================
  // request kinds
  typedef enum logic [1:0] {
    NVS_OP_READ,
    NVS_OP_WRITE,
    NVS_OP_SOFT,
    NVS_OP_HW_SAVE
  } nvs_op_e;

  // ==========================================================
  // time to cycles: least times round up, longest round down
  function automatic int nvs_min_cyc(input int ns, input int mhz);
    int c;
    c = (ns * mhz + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int nvs_max_cyc(input int ns, input int mhz);
    int c;
    c = (ns * mhz) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

endpackage

// >>> pkg/nvs_tmr_if.sv
`timescale 1ns/1ps
`include "nvs_consts.svh"

interface nvs_tmr_if;
  logic load;
  logic [`NVS_TMR_W-1:0] count;
  logic done;

  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// >>> core/nvs_timer.sv
`timescale 1ns/1ps
`include "nvs_consts.svh"

module nvs_timer
  import nvs_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // control
  nvs_tmr_if.tmr tmr
);

  logic [`NVS_TMR_W-1:0] cnt_r;

  // ==========================================================
  // down counter, reload wins over counting
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_r <= '0;
    end else if (tmr.load) begin
      cnt_r <= tmr.count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - `NVS_TMR_W'(1);
    end
  end

  assign tmr.done = (cnt_r == '0) && !tmr.load;

endmodule // nvs_timer

// >>> core/nvs_host.sv
`timescale 1ns/1ps
`include "nvs_consts.svh"

module nvs_host
  import nvs_pkg::*;
#(
  parameter int AW = `NVS_ADDR_W,
  parameter int DW = `NVS_DATA_W,
  parameter int SOFT_SEQ_LATENCY_CYC =
    `NVS_SOFT_SEQ_LATENCY_US * 1000 * `NVS_CLK_MHZ / 1000,
  // sequence addresses, entry 0 in the low bits; defaults are arbitrary
  parameter logic [`NVS_SEQ_LEN*AW-1:0] SEQ_STORE_ADDRS = '0,
  parameter logic [`NVS_SEQ_LEN*AW-1:0] SEQ_RECALL_ADDRS = '1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // request
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic req_recall_in,
  input wire logic req_oe_mode_in,
  input wire logic [AW-1:0] req_addr_in,
  input wire logic [DW-1:0] req_wdata_in,
  output logic req_ready_out,
  // answer
  output logic rsp_valid_out,
  output logic [DW-1:0] rsp_rdata_out,
  // memory pins
  output logic mem_ce_n_out,
  output logic mem_we_n_out,
  output logic mem_oe_n_out,
  output logic [AW-1:0] mem_addr_out,
  input wire logic [DW-1:0] mem_dq_in,
  output logic [DW-1:0] mem_dq_out,
  output logic mem_dq_oe_n_out,
  // save request and busy pin, open drain
  input wire logic hw_save_busy_n_in,
  output logic hw_save_busy_n_out,
  output logic hw_save_busy_n_oe_n_out
);

  // ==========================================================
  // cycle counts
  localparam int RD_CYC = nvs_min_cyc(`NVS_RD_CYCLE_NS, `NVS_CLK_MHZ) + `NVS_SYNC_STAGES;
  localparam int WR_CYC = nvs_min_cyc(`NVS_WR_PULSE_NS, `NVS_CLK_MHZ);
  localparam int HW_CYC = nvs_min_cyc(`NVS_HW_PULSE_MIN_NS, `NVS_CLK_MHZ);
  localparam int REL_CYC =
    nvs_max_cyc(`NVS_NO_WRITE_RELEASE_NS, `NVS_CLK_MHZ) + `NVS_SYNC_STAGES;

  if (AW < 1 || DW < 1 || SOFT_SEQ_LATENCY_CYC < 1 ||
      SOFT_SEQ_LATENCY_CYC >= (1 << `NVS_TMR_W)) begin : g_param_chk
    $error("nvs_host: parameter out of range");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_CHECK, ST_RD, ST_RD_WAIT, ST_GAP, ST_WR, ST_WR_WAIT,
    ST_WR_HOLD, ST_HW_START, ST_HW_WAIT, ST_HW_REL, ST_SS_START, ST_PAUSE,
    ST_POLL, ST_DONE
  } nvs_state_e;

  nvs_state_e st_r;
  nvs_op_e op_r;
  logic recall_r;
  logic oe_mode_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [2:0] idx_r;
  logic [DW-1:0] dq_m_r;
  logic [DW-1:0] dq_s_r;
  logic busy_m_r;
  logic busy_s_r;

  nvs_tmr_if tmr_if ();

  nvs_timer u_timer (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .tmr(tmr_if.tmr)
  );

  function automatic logic [AW-1:0] seq_addr(input logic rc, input logic [2:0] i);
    logic [`NVS_SEQ_LEN*AW-1:0] tbl;
    tbl = rc ? SEQ_RECALL_ADDRS : SEQ_STORE_ADDRS;
    return tbl[i*AW +: AW];
  endfunction

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dq_m_r <= '0;
      dq_s_r <= '0;
      busy_m_r <= 1'b1;
      busy_s_r <= 1'b1;
    end else begin
      dq_m_r <= mem_dq_in;
      dq_s_r <= dq_m_r;
      busy_m_r <= hw_save_busy_n_in;
      busy_s_r <= busy_m_r;
    end
  end

  // ==========================================================
  // timer loads on entry to each timed state
  always_comb begin
    tmr_if.load = 1'b1;
    tmr_if.count = '0;
    case (st_r)
      ST_RD: tmr_if.count = `NVS_TMR_W'(RD_CYC);
      ST_WR: tmr_if.count = `NVS_TMR_W'(WR_CYC);
      ST_HW_START: tmr_if.count = `NVS_TMR_W'(HW_CYC);
      ST_HW_REL: tmr_if.count = `NVS_TMR_W'(REL_CYC);
      ST_SS_START: tmr_if.count = `NVS_TMR_W'(SOFT_SEQ_LATENCY_CYC);
      default: tmr_if.load = 1'b0;
    endcase
  end

  // ==========================================================
  // request latch and sequencing
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r <= ST_IDLE;
      op_r <= NVS_OP_READ;
      recall_r <= 1'b0;
      oe_mode_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      idx_r <= 3'h0;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          req_ready_out <= 1'b1;
          if (req_valid_in && req_ready_out) begin
            req_ready_out <= 1'b0;
            op_r <= nvs_op_e'(req_op_in);
            recall_r <= req_recall_in;
            oe_mode_r <= req_oe_mode_in;
            addr_r <= req_addr_in;
            wdata_r <= req_wdata_in;
            idx_r <= 3'h0;
            st_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (busy_s_r) begin
            case (op_r)
              NVS_OP_WRITE: st_r <= ST_WR;
              NVS_OP_HW_SAVE: st_r <= ST_HW_START;
              default: st_r <= ST_RD;
            endcase
          end
        end
        ST_RD: st_r <= ST_RD_WAIT;
        ST_RD_WAIT: begin
          if (tmr_if.done) begin
            if (op_r != NVS_OP_SOFT) begin
              rsp_rdata_out <= dq_s_r;
              rsp_valid_out <= 1'b1;
              st_r <= ST_DONE;
            end else if (idx_r == 3'(`NVS_SEQ_LAST)) begin
              st_r <= ST_SS_START;
            end else begin
              idx_r <= idx_r + 3'h1;
              st_r <= ST_GAP;
            end
          end
        end
        ST_GAP: st_r <= ST_RD;
        ST_WR: st_r <= ST_WR_WAIT;
        ST_WR_WAIT: begin
          if (tmr_if.done) begin
            st_r <= ST_WR_HOLD;
          end
        end
        ST_WR_HOLD: begin
          rsp_valid_out <= 1'b1;
          st_r <= ST_DONE;
        end
        ST_HW_START: st_r <= ST_HW_WAIT;
        ST_HW_WAIT: begin
          if (tmr_if.done) begin
            st_r <= ST_HW_REL;
          end
        end
        ST_HW_REL: st_r <= ST_PAUSE;
        ST_SS_START: st_r <= ST_PAUSE;
        ST_PAUSE: begin
          if (tmr_if.done) begin
            st_r <= ST_POLL;
          end
        end
        ST_POLL: begin
          if (busy_s_r) begin
            rsp_valid_out <= 1'b1;
            st_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          rsp_valid_out <= 1'b0;
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // memory pin drivers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mem_ce_n_out <= 1'b1;
      mem_we_n_out <= 1'b1;
      mem_oe_n_out <= 1'b1;
      mem_addr_out <= '0;
      mem_dq_out <= '0;
      mem_dq_oe_n_out <= 1'b1;
    end else begin
      case (st_r)
        ST_RD: begin
          mem_addr_out <= (op_r == NVS_OP_SOFT) ? seq_addr(recall_r, idx_r) : addr_r;
          mem_ce_n_out <= 1'b0;
          mem_oe_n_out <= 1'b0;
          mem_we_n_out <= 1'b1;
          mem_dq_oe_n_out <= 1'b1;
        end
        ST_RD_WAIT: begin
          if (tmr_if.done) begin
            if (!(op_r == NVS_OP_SOFT && oe_mode_r && idx_r != 3'(`NVS_SEQ_LAST))) begin
              mem_ce_n_out <= 1'b1;
            end
            mem_oe_n_out <= 1'b1;
          end
        end
        ST_WR: begin
          mem_addr_out <= addr_r;
          mem_ce_n_out <= 1'b0;
          mem_we_n_out <= 1'b0;
          mem_oe_n_out <= 1'b1;
          mem_dq_out <= wdata_r;
          mem_dq_oe_n_out <= 1'b0;
        end
        ST_WR_WAIT: begin
          if (tmr_if.done) begin
            mem_we_n_out <= 1'b1;
            mem_ce_n_out <= 1'b1;
          end
        end
        ST_WR_HOLD: mem_dq_oe_n_out <= 1'b1;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // save request pin, released except during the request pulse
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hw_save_busy_n_out <= 1'b0;
      hw_save_busy_n_oe_n_out <= 1'b1;
    end else begin
      hw_save_busy_n_out <= 1'b0;
      if (st_r == ST_HW_START) begin
        hw_save_busy_n_oe_n_out <= 1'b0;
      end else if (st_r == ST_HW_REL) begin
        hw_save_busy_n_oe_n_out <= 1'b1;
      end
    end
  end

endmodule // nvs_host

// >>> test/nvs_host_props.sv
`timescale 1ns/1ps

module nvs_host_props #(
  parameter int AW = 15
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // watched ports
  input wire logic req_ready_out,
  input wire logic mem_ce_n_out,
  input wire logic mem_we_n_out,
  input wire logic mem_oe_n_out,
  input wire logic [AW-1:0] mem_addr_out,
  input wire logic mem_dq_oe_n_out,
  input wire logic hw_save_busy_n_in,
  input wire logic hw_save_busy_n_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // ======
  // sequences
  sequence s_pull_low;
    !hw_save_busy_n_oe_n_out [*4];
  endsequence
  sequence s_read_low;
    !mem_oe_n_out [*7];
  endsequence
  // ======
  // assertions
  idle_pins_a:
    assert property (req_ready_out |-> mem_ce_n_out && mem_we_n_out && mem_oe_n_out)
    else $error("strobes active while idle");
  write_drive_a:
    assert property (!mem_we_n_out |-> !mem_ce_n_out && !mem_dq_oe_n_out)
    else $error("write without select or data");
  read_release_a:
    assert property (!mem_oe_n_out |-> mem_dq_oe_n_out && mem_we_n_out)
    else $error("read with write strobe or data driven");
  busy_quiet_a:
    assert property (!mem_ce_n_out |-> hw_save_busy_n_oe_n_out)
    else $error("save pin pulled during access");
  save_pulse_a:
    assert property ($fell(hw_save_busy_n_oe_n_out) |-> s_pull_low)
    else $error("save pulse too short");
  read_width_a:
    assert property ($fell(mem_oe_n_out) |-> s_read_low)
    else $error("read strobe too short");
  addr_hold_a:
    assert property (!mem_ce_n_out && !mem_oe_n_out && !$past(mem_ce_n_out)
      && !$past(mem_oe_n_out) |-> $stable(mem_addr_out))
    else $error("address moved during read");
  busy_block_a:
    assert property ((!hw_save_busy_n_in) [*6] |=> !$fell(mem_ce_n_out))
    else $error("access started while busy");
endmodule // nvs_host_props

// >>> test/nvs_mem_model.sv
`timescale 1ns/1ps

module nvs_mem_model #(
  parameter logic [89:0] ST = '0,
  parameter logic [89:0] RC = '0,
  parameter int SV = 40,
  parameter int LAT = 10
) (
  // clock
  input wire logic clk_in,
  // memory pins
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [14:0] addr_in,
  input wire logic [7:0] dq_in,
  input wire logic dq_oe_n_in,
  output logic [7:0] dq_pin_out,
  // save pin
  input wire logic busy_oe_n_in,
  input wire logic busy_drv_in,
  output logic busy_pin_out
);
  logic [7:0] mem [16];
  logic [7:0] nv [16];
  logic [7:0] last_r = 8'h00;
  logic rd_q = 1'b0;
  logic wl_r = 1'b0;
  logic rcl_r = 1'b0;
  logic rd;
  int bc = 0;
  int pc = 0;
  int si = 0;
  int ri = 0;
  assign rd = !ce_n_in && !oe_n_in && we_n_in;
  assign dq_pin_out = !dq_oe_n_in ? dq_in :
    (rd && bc == 0 && pc == 0) ? mem[addr_in[3:0]] : ~last_r;
  assign busy_pin_out = (busy_oe_n_in || busy_drv_in) && bc == 0;
  always_ff @(posedge clk_in) begin
    last_r <= dq_pin_out;
    rd_q <= rd;
    if (bc > 0) begin
      bc <= bc - 1;
      if (bc == 1 && rcl_r) mem <= nv;
    end
    if (!busy_oe_n_in && !busy_drv_in && bc == 0 && pc == 0 && wl_r) begin
      nv <= mem;
      wl_r <= 1'b0;
      rcl_r <= 1'b0;
      bc <= SV;
    end
    if (!ce_n_in && !we_n_in && bc == 0) begin
      mem[addr_in[3:0]] <= dq_pin_out;
      wl_r <= 1'b1;
      si <= 0;
      ri <= 0;
    end
    if (rd && !rd_q && bc == 0 && pc == 0) begin
      si <= (addr_in == ST[si*15 +: 15]) ? si + 1 : 0;
      ri <= (addr_in == RC[ri*15 +: 15]) ? ri + 1 : 0;
    end
    if (si == 6 || ri == 6) begin
      pc <= LAT;
      rcl_r <= (ri == 6);
      si <= 0;
      ri <= 0;
    end
    if (pc > 0) begin
      pc <= pc - 1;
      if (pc == 1) begin
        bc <= SV;
        if (!rcl_r) nv <= mem;
        if (!rcl_r) wl_r <= 1'b0;
      end
    end
  end
endmodule // nvs_mem_model

// >>> test/test_nvsram_store_control_port.sv
`timescale 1ns/1ps

module test_nvsram_store_control_port;
  import nvs_pkg::*;
  localparam logic [89:0] ST = {15'h6, 15'h5, 15'h4, 15'h3, 15'h2, 15'h1};
  localparam logic [89:0] RC = {15'hC, 15'hB, 15'hA, 15'h9, 15'h8, 15'h7};
  localparam int SV = 40;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic [1:0] req_op_in = 2'h0;
  logic req_recall_in = 1'b0;
  logic req_oe_mode_in = 1'b0;
  logic [14:0] req_addr_in = 15'h0;
  logic [7:0] req_wdata_in = 8'h00;
  logic req_ready_out, rsp_valid_out, mem_ce_n_out, mem_we_n_out, mem_oe_n_out;
  logic mem_dq_oe_n_out, hw_save_busy_n_out, hw_save_busy_n_oe_n_out, busy_pin;
  logic [7:0] rsp_rdata_out, mem_dq_out, dq_pin;
  logic [14:0] mem_addr_out;
  int error_cnt = 0;
  int cmp_count = 0;

  nvs_host #(.SOFT_SEQ_LATENCY_CYC(20), .SEQ_STORE_ADDRS(ST), .SEQ_RECALL_ADDRS(RC)) u_dut (
    .clk_in, .srst_in, .req_valid_in, .req_op_in, .req_recall_in, .req_oe_mode_in,
    .req_addr_in, .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out,
    .mem_ce_n_out, .mem_we_n_out, .mem_oe_n_out, .mem_addr_out, .mem_dq_in(dq_pin),
    .mem_dq_out, .mem_dq_oe_n_out, .hw_save_busy_n_in(busy_pin), .hw_save_busy_n_out,
    .hw_save_busy_n_oe_n_out);
  nvs_mem_model #(.ST(ST), .RC(RC), .SV(SV)) u_mem (
    .clk_in, .ce_n_in(mem_ce_n_out), .we_n_in(mem_we_n_out), .oe_n_in(mem_oe_n_out),
    .addr_in(mem_addr_out), .dq_in(mem_dq_out), .dq_oe_n_in(mem_dq_oe_n_out),
    .dq_pin_out(dq_pin), .busy_oe_n_in(hw_save_busy_n_oe_n_out),
    .busy_drv_in(hw_save_busy_n_out), .busy_pin_out(busy_pin));

  initial begin
    forever #2 clk_in = ~clk_in;
  end
  // ======
  // helpers
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic op(input nvs_op_e o, input logic rc, input logic om,
    input logic [14:0] a, input logic [7:0] d, output int n);
    @(posedge clk_in);
    req_op_in <= o;
    req_recall_in <= rc;
    req_oe_mode_in <= om;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_valid_in <= 1'b1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (req_ready_out !== 1'b1 && n < 9000);
    req_valid_in <= 1'b0;
    if (n >= 9000) begin chk(8'h01, 8'h00); conclude(); end
    n = 0;
    do begin @(posedge clk_in); n++; end while (rsp_valid_out !== 1'b1 && n < 9000);
    if (n >= 9000) begin chk(8'h01, 8'h00); conclude(); end
  endtask
  // ======
  // scenarios
  task automatic t_rw();
    int n;
    op(NVS_OP_WRITE, 1'b0, 1'b0, 15'h1, 8'h5A, n);
    op(NVS_OP_READ, 1'b0, 1'b0, 15'h1, 8'h00, n);
    chk(8'h5A, rsp_rdata_out);
  endtask
  task automatic t_hw();
    int n;
    op(NVS_OP_HW_SAVE, 1'b0, 1'b0, 15'h0, 8'h00, n);
    chk(8'h01, 8'(n > SV));
    op(NVS_OP_HW_SAVE, 1'b0, 1'b0, 15'h0, 8'h00, n);
    chk(8'h01, 8'(n < SV));
  endtask
  task automatic t_soft();
    int n;
    logic [7:0] last_rd;
    last_rd = 8'h5A;
    for (int m = 0; m < 2; m++) begin
      op(NVS_OP_WRITE, 1'b0, 1'b0, 15'h1, 8'hC3 + 8'(m), n);
      op(NVS_OP_SOFT, 1'b0, 1'(m), 15'h0, 8'h00, n);
      chk(last_rd, rsp_rdata_out);
      op(NVS_OP_HW_SAVE, 1'b0, 1'b0, 15'h0, 8'h00, n);
      chk(8'h01, 8'(n < SV));
      op(NVS_OP_WRITE, 1'b0, 1'b0, 15'h1, 8'h77, n);
      op(NVS_OP_SOFT, 1'b1, 1'(1 - m), 15'h0, 8'h00, n);
      chk(last_rd, rsp_rdata_out);
      op(NVS_OP_READ, 1'b0, 1'b0, 15'h1, 8'h00, n);
      chk(8'hC3 + 8'(m), rsp_rdata_out);
      last_rd = 8'hC3 + 8'(m);
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    t_rw();
    t_hw();
    t_soft();
    conclude();
  end
endmodule // test_nvsram_store_control_port

bind nvs_host nvs_host_props #(.AW(AW)) u_props (
  .clk_in, .srst_in, .req_ready_out, .mem_ce_n_out, .mem_we_n_out, .mem_oe_n_out,
  .mem_addr_out, .mem_dq_oe_n_out, .hw_save_busy_n_in, .hw_save_busy_n_oe_n_out);
